//--- logic/osw_params.svh
// Purpose: Shared constants of the octal switch serial link and its host
// Assumes: 100 MHz system clock on both ends
// Notes:   Times in microseconds, counts derived in the modules
`ifndef OSW_PARAMS_SVH
`define OSW_PARAMS_SVH

// Clock and word sizes
`define OSW_CLK_MHZ      100
`define OSW_NOUT         8
`define OSW_LONG_BITS    16
`define OSW_TMR_W        16
`define OSW_CNT_W        5
`define OSW_SYNC_STAGES  2

// Open-load filter and write spacing
`define OSW_FILTER_US    100
`define OSW_GAP_US       300

// Serial clock half period less one, in system cycles; leaves room for both synchronisers
`define OSW_SCLK_HALF    5'h08

// Host register offsets and fields
`define OSW_ADDR_W       4
`define OSW_DATA_W       32
`define OSW_REG_CTRL     4'h0
`define OSW_REG_TX       4'h4
`define OSW_REG_RX       4'h8
`define OSW_REG_STAT     4'hc
`define OSW_CTRL_START   0
`define OSW_CTRL_LONG    1
`define OSW_STAT_BUSY    0
`define OSW_STAT_DONE    1
`define OSW_STAT_PEND    2
`define OSW_STAT_LONG    3

`endif

//--- logic/osw_pkg.sv
// Purpose: Types shared by both ends of the octal switch link
// Assumes: osw_params.svh supplies widths
// Notes:   Types only, no numbers of their own
`include "osw_params.svh"
package osw_pkg;
    typedef logic [`OSW_NOUT-1:0]      osw_word_t;
    typedef logic [`OSW_LONG_BITS-1:0] osw_long_t;
    typedef logic [`OSW_TMR_W-1:0]     osw_tmr_t;
    typedef logic [`OSW_CNT_W-1:0]     osw_cnt_t;
    typedef enum logic [2:0] {
        HS_IDLE,
        HS_SETUP,
        HS_HIGH,
        HS_LOW,
        HS_HOLD
    } osw_host_state_e;
endpackage

//--- logic/osw_if.sv
// Purpose: Serial link between host master and switch device
// Assumes: Device drives its status line only while selected
// Notes:   Undriven status line resolves high, as a pull-up would
interface osw_if;
    logic csN;
    logic sclk;
    logic serialCommandInput;
    logic statusOut;
    logic statusOe;
    logic statusLine;

    // Wire level of the shared status line
    assign statusLine = statusOe ? statusOut : 1'b1;

    modport host (
        output csN,
        output sclk,
        output serialCommandInput,
        input  statusLine
    );
    modport device (
        input  csN,
        input  sclk,
        input  serialCommandInput,
        output statusOut,
        output statusOe
    );
endinterface

//--- logic/osw_sync.sv
// Purpose: Two-stage synchroniser for a group of foreign levels
// Assumes: Each bit is an independent level
// Notes:   First stage is read by the second stage only
module osw_sync
    import osw_pkg::*;
#(
    parameter int W = 1
) (
    // Clock, reset, enable
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // Two flops; metastability settles in the first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

//--- logic/osw_device.sv
// Purpose: Serial control and fault logic of an eight-output power switch
// Assumes: Link pins and fault sensors are foreign levels, synchronised here
// Notes:   rst_n stands for the logic-supply undervoltage reset
`include "osw_params.svh"

// Operation
// - Command one drives on; faults read one
// - Chain passes status toward host under select
// - Rising select applies shift register to outputs
// - Host selects parallel devices by own lines
// - Host turns outputs off before sleep
// - Status word shifts out while command in
// - Host classifies faults by previous command
// - Host spaces writes over 300 us
// - Sixteen-bit check echoes first byte back
// - Overtemperature turns off only that output
// - Output returns after cooling unless commanded off
// - Load-supply overvoltage forces all off, restores
// - Open load checked only while commanded off
// - Open-load faults filtered after switching
// - Rising select starts filter timer
// - Open-load fault latched until read
// - Short shuts output, retries until cleared
// - Logic undervoltage: outputs off, status cleared
// - Load undervoltage keeps outputs following command
// - Sample falling, shift rising, clock low
// - Falling select loads status, enables output
// - Most significant bit first, output eight
// - Deselected: ignore clock and data, float
module osw_device
    import osw_pkg::*;
#(
    parameter int FILTER_CYCLES = `OSW_FILTER_US * `OSW_CLK_MHZ
) (
    // Clock, reset, enable
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire logic      ce,
    // Serial link
    osw_if.device          link,
    // Fault sensors, one bit per output except the single load-supply overvoltage bit, foreign levels
    input  wire osw_word_t overTemp,
    input  wire osw_word_t overCurrent,
    input  wire osw_word_t openLoadCmp,
    input  wire logic      loadSupplyOverVolt,
    // Power stage and visibility
    output osw_word_t      drive,
    output osw_word_t      commandWord,
    output osw_word_t      faultStatusRegister
);
    localparam int SENS_W = 3 * `OSW_NOUT + 1;
    localparam osw_tmr_t FILTER_LOAD = osw_tmr_t'(FILTER_CYCLES);

    logic [2:0]        linkRaw;
    logic [2:0]        linkS;
    logic [SENS_W-1:0] sensRaw;
    logic [SENS_W-1:0] sensS;
    logic              csS;
    logic              sclkS;
    logic              dataS;
    logic              csD;
    logic              sclkD;
    logic              csFall;
    logic              csRise;
    logic              sclkFall;
    logic              sclkRise;
    osw_word_t         otS;
    osw_word_t         ocS;
    osw_word_t         olS;
    logic              ovS;
    osw_word_t         shiftReg;
    logic              outBit;
    logic              outEn;
    osw_tmr_t          filterCnt;
    logic              filterDone;
    osw_word_t         openLatch;
    osw_word_t         next_openLatch;
    osw_word_t         liveFault;
    osw_word_t         next_drive;

    // Link pins cross into the clock domain; select enters inverted so a reset chain reads idle
    assign linkRaw = {~link.csN, link.sclk, link.serialCommandInput};

    osw_sync #(.W(3)) u_linkSync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     (linkRaw),
        .q     (linkS)
    );

    // Sensor levels act without the serial clock, only the system clock
    assign sensRaw = {overTemp, overCurrent, openLoadCmp, loadSupplyOverVolt};

    osw_sync #(.W(SENS_W)) u_sensSync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     (sensRaw),
        .q     (sensS)
    );

    assign csS   = ~linkS[2];
    assign sclkS = linkS[1];
    assign dataS = linkS[0];
    assign otS   = sensS[SENS_W-1 -: `OSW_NOUT];
    assign ocS   = sensS[2*`OSW_NOUT -: `OSW_NOUT];
    assign olS   = sensS[`OSW_NOUT -: `OSW_NOUT];
    assign ovS   = sensS[0];

    // Edge history; select idles high so reset matches an idle link
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            csD   <= 1'b1;
            sclkD <= 1'b0;
        end else if (ce) begin
            csD   <= csS;
            sclkD <= sclkS;
        end
    end

    // Clock edges count only while selected
    assign csFall   = csD & ~csS;
    assign csRise   = ~csD & csS;
    assign sclkFall = ~csS & sclkD & ~sclkS;
    assign sclkRise = ~csS & ~sclkD & sclkS;

    // Shift register: status loaded at select, data in at falling clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shiftReg <= '0;
        end else if (ce) begin
            if (csFall) begin
                shiftReg <= faultStatusRegister;
            end else if (sclkFall) begin
                shiftReg <= {shiftReg[`OSW_NOUT-2:0], dataS};
            end
        end
    end

    // Status pin: next bit on rising clock, driven only while selected
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outBit <= 1'b0;
            outEn  <= 1'b0;
        end else if (ce) begin
            outEn <= ~csS;
            if (csFall) begin
                outBit <= 1'b0;
            end else if (sclkRise) begin
                outBit <= shiftReg[`OSW_NOUT-1];
            end
        end
    end

    assign link.statusOut = outBit;
    assign link.statusOe  = outEn;

    // Command latch; undervoltage reset leaves every output commanded off
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            commandWord <= '0;
        end else if (ce && csRise) begin
            commandWord <= shiftReg;
        end
    end

    // Filter timer restarted by every command; comparator blind until zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            filterCnt <= FILTER_LOAD;
        end else if (ce) begin
            if (csRise) begin
                filterCnt <= FILTER_LOAD;
            end else if (!filterDone) begin
                filterCnt <= filterCnt - osw_tmr_t'(1);
            end
        end
    end

    assign filterDone = (filterCnt == '0);

    // Open-load latch: set wins over the clear done by the status read
    always_comb begin
        next_openLatch = openLatch;
        if (csFall) begin
            next_openLatch = '0;
        end
        if (filterDone) begin
            next_openLatch = next_openLatch | (olS & ~commandWord);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            openLatch <= '0;
        end else if (ce) begin
            openLatch <= next_openLatch;
        end
    end

    // On-state faults report live; open load reports from the latch
    assign liveFault = commandWord & (otS | ocS);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            faultStatusRegister <= '0;
        end else if (ce) begin
            faultStatusRegister <= next_openLatch | liveFault;
        end
    end

    // Drivers follow command; thermal and overvoltage masks need no retry state
    always_comb begin
        next_drive = commandWord & ~otS & ~ocS;
        if (ovS) begin
            next_drive = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drive <= '0;
        end else if (ce) begin
            drive <= next_drive;
        end
    end
endmodule

//--- logic/osw_host.sv
// Purpose: Host-side serial master for the octal switch
// Assumes: Software drives a plain register port with one-cycle strobes
// Notes:   Serial clock is divided from clk; status line is synchronised
//
// The placing of the registers and the strobed register port were left to the implementer.
`include "osw_params.svh"
module osw_host
    import osw_pkg::*;
#(
    parameter int GAP_CYCLES = `OSW_GAP_US * `OSW_CLK_MHZ
) (
    // Clock, reset, enable
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   ce,
    // Register port
    input  wire logic [`OSW_ADDR_W-1:0] regAddr,
    input  wire logic [`OSW_DATA_W-1:0] regWdata,
    input  wire logic                   regWr,
    input  wire logic                   regRd,
    output logic      [`OSW_DATA_W-1:0] regRdata,
    // Serial link
    osw_if.host                         link
);
    localparam osw_tmr_t GAP_LOAD = osw_tmr_t'(GAP_CYCLES);

    osw_host_state_e state;
    osw_cnt_t        phCnt;
    osw_cnt_t        bitsLeft;
    osw_tmr_t        gapCnt;
    osw_long_t       txShift;
    osw_long_t       rxShift;
    osw_long_t       txData;
    osw_long_t       rxData;
    logic            longMode;
    logic            pending;
    logic            done;
    logic            misoS;
    logic            phEnd;
    logic            launch;
    logic            finish;
    logic            statRead;

    osw_sync #(.W(1)) u_misoSync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     (link.statusLine),
        .q     (misoS)
    );

    assign phEnd    = (phCnt == '0);
    assign launch   = (state == HS_IDLE) && pending && (gapCnt == '0);
    assign finish   = (state == HS_HOLD) && phEnd;
    assign statRead = regRd && (regAddr == `OSW_REG_STAT);

    // Link sequencer; clock is low at every select change
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state                   <= HS_IDLE;
            phCnt                   <= '0;
            bitsLeft                <= '0;
            txShift                 <= '0;
            rxShift                 <= '0;
            link.csN                <= 1'b1;
            link.sclk               <= 1'b0;
            link.serialCommandInput <= 1'b0;
        end else if (ce) begin
            phCnt <= phEnd ? `OSW_SCLK_HALF : phCnt - osw_cnt_t'(1);
            case (state)
                HS_IDLE: begin
                    if (launch) begin
                        // Short words sit in the upper byte so MSB leads
                        txShift  <= longMode ? txData : {txData[`OSW_NOUT-1:0], {`OSW_NOUT{1'b0}}};
                        link.serialCommandInput <= longMode ? txData[`OSW_LONG_BITS-1]
                                                            : txData[`OSW_NOUT-1];
                        bitsLeft <= longMode ? osw_cnt_t'(`OSW_LONG_BITS) : osw_cnt_t'(`OSW_NOUT);
                        link.csN <= 1'b0;
                        phCnt    <= `OSW_SCLK_HALF;
                        state    <= HS_SETUP;
                    end
                end
                HS_SETUP: begin
                    if (phEnd) begin
                        link.sclk <= 1'b1;
                        state     <= HS_HIGH;
                    end
                end
                HS_HIGH: begin
                    if (phEnd) begin
                        link.sclk <= 1'b0;
                        rxShift   <= {rxShift[`OSW_LONG_BITS-2:0], misoS};
                        txShift   <= {txShift[`OSW_LONG_BITS-2:0], 1'b0};
                        bitsLeft  <= bitsLeft - osw_cnt_t'(1);
                        state     <= HS_LOW;
                    end
                end
                HS_LOW: begin
                    if (phEnd) begin
                        if (bitsLeft == '0) begin
                            state <= HS_HOLD;
                        end else begin
                            // Data moves on the rising clock, away from the sampling edge
                            link.sclk               <= 1'b1;
                            link.serialCommandInput <= txShift[`OSW_LONG_BITS-1];
                            state                   <= HS_HIGH;
                        end
                    end
                end
                HS_HOLD: begin
                    if (phEnd) begin
                        link.csN                <= 1'b1;
                        link.serialCommandInput <= 1'b0;
                        state                   <= HS_IDLE;
                    end
                end
                default: begin
                    state <= HS_IDLE;
                end
            endcase
        end
    end

    // Write spacing counter, restarted as each word is applied
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gapCnt <= '0;
        end else if (ce) begin
            if (finish) begin
                gapCnt <= GAP_LOAD;
            end else if (gapCnt != '0) begin
                gapCnt <= gapCnt - osw_tmr_t'(1);
            end
        end
    end

    // Software registers; a start waits for spacing instead of being lost
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txData   <= '0;
            longMode <= 1'b0;
            pending  <= 1'b0;
        end else if (ce) begin
            if (regWr && regAddr == `OSW_REG_TX) begin
                txData <= regWdata[`OSW_LONG_BITS-1:0];
            end
            if (regWr && regAddr == `OSW_REG_CTRL) begin
                longMode <= regWdata[`OSW_CTRL_LONG];
            end
            if (regWr && regAddr == `OSW_REG_CTRL && regWdata[`OSW_CTRL_START]) begin
                pending <= 1'b1;
            end else if (launch) begin
                pending <= 1'b0;
            end
        end
    end

    // Received word and done flag; completion wins over the clearing read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxData <= '0;
            done   <= 1'b0;
        end else if (ce) begin
            if (finish) begin
                rxData <= longMode ? rxShift : {{`OSW_NOUT{1'b0}}, rxShift[`OSW_NOUT-1:0]};
            end
            if (finish) begin
                done <= 1'b1;
            end else if (statRead) begin
                done <= 1'b0;
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdata <= '0;
        end else if (ce) begin
            regRdata <= '0;
            if (regRd) begin
                case (regAddr)
                    `OSW_REG_CTRL: regRdata[`OSW_CTRL_LONG] <= longMode;
                    `OSW_REG_TX:   regRdata[`OSW_LONG_BITS-1:0] <= txData;
                    `OSW_REG_RX:   regRdata[`OSW_LONG_BITS-1:0] <= rxData;
                    `OSW_REG_STAT: begin
                        regRdata[`OSW_STAT_BUSY] <= (state != HS_IDLE);
                        regRdata[`OSW_STAT_DONE] <= done;
                        regRdata[`OSW_STAT_PEND] <= pending;
                        regRdata[`OSW_STAT_LONG] <= longMode;
                    end
                    default: regRdata <= '0;
                endcase
            end
        end
    end
endmodule

//--- bench/osw_link_props.sv
// Purpose: Wire checks on the switch serial link between host and device
// Assumes: Both ends run on clk with a synchronous active-low reset
// Notes:   Helper counters watch only the link, never the ends' insides
module osw_link_props #(
    parameter int GAP = 50
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link
    input wire logic csN,
    input wire logic sclk,
    input wire logic serialCommandInput,
    input wire logic statusOut,
    input wire logic statusOe,
    input wire logic statusLine
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GAP_MIN = GAP - 1;
    logic        prevSclk;
    logic        prevData;
    logic        fallSeen;
    logic [4:0]  riseCnt;
    logic [4:0]  fallCnt;
    logic [15:0] inHist;
    logic [15:0] gapCnt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Fall seen one cycle late, so data of the high phase is kept
    assign fallSeen = !csN && !sclk && prevSclk;
    always_ff @(posedge clk) begin
        prevSclk <= rst_n && sclk;
        prevData <= serialCommandInput;
    end

    // Bits of the current frame, history of bits sent
    always_ff @(posedge clk) begin
        if (!rst_n || csN) begin
            riseCnt <= 5'h00;
            fallCnt <= 5'h00;
            inHist  <= 16'h0000;
        end else begin
            if (sclk && !prevSclk)
                riseCnt <= riseCnt + 5'h01;
            if (fallSeen) begin
                fallCnt <= fallCnt + 5'h01;
                inHist  <= {inHist[14:0], prevData};
            end
        end
    end

    // Deselected time, saturating; reset counts as a long idle
    always_ff @(posedge clk) begin
        if (!rst_n)
            gapCnt <= 16'(GAP);
        else if (!csN)
            gapCnt <= 16'h0000;
        else if (gapCnt < 16'(GAP))
            gapCnt <= gapCnt + 16'h0001;
    end

    property p_oe_on;
        $fell(csN) |-> ##[1:6] statusOe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("status driver not enabled after select");
    property p_oe_off;
        csN [*6] |-> !statusOe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("status driven while deselected");
    property p_cs_sclk;
        $changed(csN) |-> !sclk && !$past(sclk);
    endproperty
    a_cs_sclk: assert property (p_cs_sclk) else $error("select moved with clock high");
    property p_idle_sclk;
        csN |-> !sclk;
    endproperty
    a_idle_sclk: assert property (p_idle_sclk) else $error("clock active while deselected");
    property p_phase;
        $rose(sclk) |-> sclk [*8] ##1 sclk ##1 !sclk;
    endproperty
    a_phase: assert property (p_phase) else $error("clock high phase length wrong");
    property p_shift;
        $fell(sclk) |-> $stable(statusOut);
    endproperty
    a_shift: assert property (p_shift) else $error("status moved on falling clock");
    property p_bits;
        $rose(csN) |-> riseCnt == 5'h08 || riseCnt == 5'h10;
    endproperty
    a_bits: assert property (p_bits) else $error("frame is not 8 or 16 bits");
    property p_chain;
        fallSeen && fallCnt >= 5'h08 |-> $past(statusOut) == inHist[7];
    endproperty
    a_chain: assert property (p_chain) else $error("bit not forwarded after eight stages");
    property p_gap;
        $fell(csN) |-> gapCnt >= 16'(GAP_MIN);
    endproperty
    a_gap: assert property (p_gap) else $error("writes spaced too closely");
endmodule

//--- bench/octal_switch_serial_fault_logic_test.sv
// Purpose: Self-checking bench of host and switch device joined by the link
// Assumes: Short filter and gap counts so frames stay quick
// Notes:   Sensors change only between frames; status read one frame later
`include "osw_params.svh"
module octal_switch_serial_fault_logic_test import osw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        osw_word_t cmd;
        osw_word_t ot;
        osw_word_t oc;
        osw_word_t olc;
    } osw_row_s;
    logic        clk;
    logic        rst_n;
    logic        ce;
    logic [3:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWr;
    logic        regRd;
    logic [31:0] regRdata;
    osw_word_t   overTemp;
    osw_word_t   overCurrent;
    osw_word_t   openLoadCmp;
    logic        loadSupplyOverVolt;
    osw_word_t   drive;
    osw_word_t   commandWord;
    osw_word_t   faultStatusRegister;
    logic [15:0] rx;
    logic [31:0] s;
    osw_row_s    rows [4] = '{32'ha5000000, 32'hff0180ff, 32'h0f0000f3, 32'h3c2418c3};
    int          errCount;
    int          nChecks;

    osw_if link ();
    osw_host #(.GAP_CYCLES(50)) osw_host_i (.clk(clk), .rst_n(rst_n), .ce(ce), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .link(link));
    osw_device #(.FILTER_CYCLES(20)) osw_device_i (.clk(clk), .rst_n(rst_n), .ce(ce), .link(link),
        .overTemp(overTemp), .overCurrent(overCurrent), .openLoadCmp(openLoadCmp),
        .loadSupplyOverVolt(loadSupplyOverVolt), .drive(drive), .commandWord(commandWord),
        .faultStatusRegister(faultStatusRegister));
    osw_link_props #(.GAP(50)) osw_link_props_i (.clk(clk), .rst_n(rst_n), .csN(link.csN),
        .sclk(link.sclk), .serialCommandInput(link.serialCommandInput), .statusOut(link.statusOut),
        .statusOe(link.statusOe), .statusLine(link.statusLine));

    // Free-running system clock
    always #5 clk = ~clk;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic testDone();
        $display("checks %0d errors %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr    <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic regRead(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd   <= 1'b0;
        #1;
        d = regRdata;
    endtask
    task automatic sense(input osw_word_t t, input osw_word_t c, input osw_word_t o, input logic v);
        @(posedge clk);
        overTemp           <= t;
        overCurrent        <= c;
        openLoadCmp        <= o;
        loadSupplyOverVolt <= v;
    endtask
    // One whole frame; polls done under a bound
    task automatic xfer(input logic [15:0] tx, input logic lng, output logic [15:0] r);
        logic [31:0] st;
        int          i;
        st = 32'h0;
        regWrite(`OSW_REG_TX, {16'h0000, tx});
        regWrite(`OSW_REG_CTRL, {30'h0, lng, 1'b1});
        for (i = 0; i < 2000 && st[`OSW_STAT_DONE] !== 1'b1; i++)
            regRead(`OSW_REG_STAT, st);
        check("done", {15'h0, st[`OSW_STAT_DONE]}, 16'h0001);
        regRead(`OSW_REG_RX, st);
        r = st[15:0];
    endtask

    // Hang guard, far beyond the expected run
    initial begin
        #300us;
        errCount++;
        testDone();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        {regAddr, regWdata, regWr, regRd} = '0;
        {overTemp, overCurrent, openLoadCmp, loadSupplyOverVolt} = '0;
        errCount = 0;
        nChecks = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        waitc(5);
        // Apply a command, then add faults and read them next frame
        foreach (rows[i]) begin
            sense(8'h00, 8'h00, 8'h00, 1'b0);
            xfer({8'h00, rows[i].cmd}, 1'b0, rx);
            waitc(10);
            check("commandWord", {8'h00, commandWord}, {8'h00, rows[i].cmd});
            sense(rows[i].ot, rows[i].oc, rows[i].olc, 1'b0);
            waitc(40);
            check("drive", {8'h00, drive}, {8'h00, rows[i].cmd & ~rows[i].ot & ~rows[i].oc});
            xfer({8'h00, rows[i].cmd}, 1'b0, rx);
            check("status", rx, {8'h00, (rows[i].cmd & (rows[i].ot | rows[i].oc)) | (~rows[i].cmd & rows[i].olc)});
        end
        // Open load gone before the read still reports once
        sense(8'h00, 8'h00, 8'h00, 1'b0);
        xfer(16'h0000, 1'b0, rx);
        waitc(40);
        sense(8'h00, 8'h00, 8'h01, 1'b0);
        sense(8'h00, 8'h00, 8'h00, 1'b0);
        waitc(8);
        xfer(16'h0000, 1'b0, rx);
        check("latched", rx, 16'h0001);
        // Short pulse inside the filter window is not latched
        wait (link.csN === 1'b1);
        waitc(2);
        sense(8'h00, 8'h00, 8'h01, 1'b0);
        sense(8'h00, 8'h00, 8'h00, 1'b0);
        waitc(40);
        xfer(16'h0000, 1'b0, rx);
        check("filtered", rx, 16'h0000);
        // Overvoltage forces all off; hot output returns after cooling
        xfer(16'h00a5, 1'b0, rx);
        waitc(10);
        sense(8'h00, 8'h00, 8'h00, 1'b1);
        waitc(6);
        check("drive ov", {8'h00, drive}, 16'h0000);
        sense(8'h01, 8'h00, 8'h00, 1'b0);
        waitc(6);
        check("drive hot", {8'h00, drive}, 16'h00a4);
        sense(8'h00, 8'h00, 8'h00, 1'b0);
        waitc(6);
        check("drive cool", {8'h00, drive}, 16'h00a5);
        // Clock enable low freezes the drivers against a live overvoltage
        @(posedge clk);
        ce <= 1'b0;
        sense(8'h00, 8'h00, 8'h00, 1'b1);
        waitc(6);
        check("drive frozen", {8'h00, drive}, 16'h00a5);
        sense(8'h00, 8'h00, 8'h00, 1'b0);
        ce <= 1'b1;
        // Sixteen-bit check: status first, then first byte echoed
        xfer(16'h5a3c, 1'b1, rx);
        check("echo", rx, 16'h005a);
        waitc(10);
        check("commandWord 16", {8'h00, commandWord}, 16'h003c);
        regRead(4'h2, s);
        check("unmapped", s[31:16] | s[15:0], 16'h0000);
        // Logic-supply drop in mid-run clears everything
        sense(8'h04, 8'h00, 8'h00, 1'b0);
        waitc(10);
        @(posedge clk);
        rst_n <= 1'b0;
        waitc(2);
        check("drive rst", {8'h00, drive}, 16'h0000);
        check("status rst", {8'h00, faultStatusRegister}, 16'h0000);
        check("cmd rst", {8'h00, commandWord}, 16'h0000);
        @(posedge clk);
        rst_n <= 1'b1;
        waitc(5);
        xfer(16'h0004, 1'b0, rx);
        waitc(10);
        xfer(16'h0004, 1'b0, rx);
        check("status resumed", rx, 16'h0004);
        testDone();
    end
endmodule
